/* serial_adapter_status_logic.sv */
// Purpose: Status flags, control byte and bus access of a serial adapter
// Assumes: Bus and modem pins are asynchronous; serializer strobes are local
// Notes: Status reads as one byte; transmit data passes an 8-word FIFO
// Summary of operation
// - Status read-only, select low, read high
// - Receive full sets on load, read clears
// - Carrier input high forces receive-full empty
// - Transmit empty high once data moved on
// - Data write clears, transfer strobe of last word sets empty
// - Bit 3 mirrors clear-to-send, blocks empty
// - Clear-to-send never resets the transmitter
// - Carrier rise sets loss flag, interrupts
// - Loss flag cleared by status-then-data read
// - Still high after clear: flag tracks input
// - Framing flag updated at each load into empty holding
// - Overrun on second character without read
// - Overrun shown after read, next read clears
// - Overrun cleared by read or master reset
// - Parity flag on mismatch, odd means odd
// - No parity: generation and check suppressed
// - Bit 7 is complement of interrupt pin
// - Divide bits both high: master reset
// - Control bit 7 enables receive interrupts
// - Interrupt held while enabled cause present
// - Transmit interrupt only for code 01
`include "serial_adapter_map.svh"
module serial_adapter_status_logic
	import serial_adapter_pkg::*;
#(
	parameter int FIFO_DEPTH = `TX_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Processor bus pins
	input wire logic i_enable,
	input wire logic i_chip_sel,
	input wire logic i_register_select,
	input wire logic i_read_write,
	input wire logic [7:0] i_data_in,
	output logic [7:0] o_data_out,
	output logic o_data_oe,
	// Modem inputs
	input wire logic i_clear_to_send,
	input wire logic i_carrier_loss_input,
	// Open-drain interrupt pin
	output logic o_irq_out,
	output logic o_irq_oe,
	// Transmitter side
	output logic o_tx_valid,
	output logic [7:0] o_tx_char,
	input wire logic i_tx_take,
	// Receiver side
	input wire logic i_rx_load,
	input wire logic [7:0] i_rx_char,
	input wire logic i_rx_parity_bit,
	input wire logic i_rx_stop_missing,
	// Control outputs to serializers
	output logic [1:0] o_divide_sel,
	output logic [2:0] o_word_sel,
	output logic [1:0] o_tx_control,
	output logic o_tx_parity_en,
	output logic o_parity_odd,
	output logic o_rx_init,
	output logic o_tx_init
);

	adapter_s st; // Present state
	adapter_s next_st; // Next state
	access_e acc; // Access at this falling edge
	logic fall; // Falling enable edge
	logic mr; // Master reset held
	logic dcd_rise; // Carrier input rising
	logic par_en; // Parity selected
	logic odd_sel; // Odd parity selected
	logic eight; // Eight data bits
	logic rx_ones; // Xor of received bits
	logic transmit_empty_flag; // Transmit empty shown
	logic tx_irq_en; // Transmit interrupt enabled
	logic cause; // Enabled interrupt cause
	logic clear_seq; // Status then data read
	logic full_after; // Receive full after read
	logic [7:0] status_byte; // Assembled status
	logic fifo_ready; // Buffer can take a write
	logic fifo_valid; // Buffer holds a character
	logic fifo_rst; // Buffer flush

	assign mr = (st.control[`CR_DIV1:`CR_DIV0] == `CR_MR_CODE);
	assign fifo_rst = i_rst || mr;

	status_fifo #(
		.WIDTH(`TX_FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.i_clk(i_clk),
		.i_rst(fifo_rst),
		.i_valid(acc == ACC_TDATA),
		.o_ready(fifo_ready),
		.i_data(st.d_s),
		.o_valid(fifo_valid),
		.i_ready(i_tx_take),
		.o_data(o_tx_char)
	);

	// Decode word format and flags
	always_comb begin
		fall = st.e_p && !st.e_s;
		dcd_rise = st.dcd_s && !st.dcd_p;
		eight = st.control[`CR_WS2];
		odd_sel = st.control[`CR_WS0];
		par_en = !(st.control[`CR_WS2] && !st.control[`CR_WS1]);
		rx_ones = ^{i_rx_char[7] & eight, i_rx_char[6:0], i_rx_parity_bit};
		transmit_empty_flag = !fifo_valid && !st.cts_s;
		tx_irq_en = (st.control[`CR_TX1:`CR_TX0] == `CR_TXIRQ_CODE);
		status_byte[`ST_RXF] = st.rx_full && !st.dcd_s;
		status_byte[`ST_TRANSMIT_EMPTY_FLAG] = transmit_empty_flag;
		status_byte[`ST_CARRIER] = st.carrier;
		status_byte[`ST_CTS] = st.cts_s;
		status_byte[`ST_FE] = st.framing;
		status_byte[`ST_OVR] = st.overrun;
		status_byte[`ST_PE] = st.parity && par_en;
		status_byte[`ST_IRQ] = st.irq;
		cause = (st.control[`CR_RIE] && (status_byte[`ST_RXF] || st.carrier))
			|| (tx_irq_en && transmit_empty_flag);
	end

	// Bus access decode at the falling enable edge
	always_comb begin
		acc = ACC_NONE;
		if (fall && st.cs_s) begin
			case ({st.rs_s, st.rw_s})
				2'b01: acc = ACC_STATUS;
				2'b11: acc = ACC_RDATA;
				2'b00: acc = ACC_CTRL;
				2'b10: acc = ACC_TDATA;
				default: acc = ACC_NONE;
			endcase
		end
	end

	// Next state of all flags and pins
	always_comb begin
		next_st = st;
		clear_seq = 1'b0;
		full_after = st.rx_full;
		// Two-stage pin synchronisers
		next_st.e_m = i_enable;
		next_st.e_s = st.e_m;
		next_st.e_p = st.e_s;
		next_st.cs_m = i_chip_sel;
		next_st.cs_s = st.cs_m;
		next_st.rs_m = i_register_select;
		next_st.rs_s = st.rs_m;
		next_st.rw_m = i_read_write;
		next_st.rw_s = st.rw_m;
		next_st.d_m = i_data_in;
		next_st.d_s = st.d_m;
		next_st.cts_m = i_clear_to_send;
		next_st.cts_s = st.cts_m;
		next_st.dcd_m = i_carrier_loss_input;
		next_st.dcd_s = st.dcd_m;
		next_st.dcd_p = st.dcd_s;
		// Drive bus while a read is selected
		next_st.doe = st.e_s && st.cs_s && st.rw_s;
		next_st.dout = st.rs_s ? st.holding : status_byte;
		// Effects of the access
		case (acc)
			ACC_STATUS: begin
				next_st.stat_seen = 1'b1;
			end
			ACC_RDATA: begin
				clear_seq = st.stat_seen;
				next_st.stat_seen = 1'b0;
				if (st.ovr_pend) begin
					next_st.overrun = 1'b1;
					next_st.ovr_pend = 1'b0;
					full_after = 1'b1;
				end else begin
					next_st.overrun = 1'b0;
					full_after = 1'b0;
				end
			end
			ACC_CTRL: begin
				next_st.control = st.d_s;
			end
			ACC_TDATA: begin
				// Buffer takes the write when ready
				next_st.stat_seen = st.stat_seen;
			end
			default: begin
				next_st.stat_seen = st.stat_seen;
			end
		endcase
		next_st.rx_full = full_after;
		// Receive transfer from the deserializer
		if (i_rx_load) begin
			if (!full_after) begin
				next_st.rx_full = 1'b1;
				next_st.holding = i_rx_char;
				next_st.framing = i_rx_stop_missing;
				next_st.parity = par_en && (rx_ones ^ odd_sel);
			end else begin
				next_st.ovr_pend = 1'b1;
			end
		end
		// Carrier loss tracking
		if (dcd_rise) begin
			next_st.carrier = 1'b1;
		end else if (clear_seq) begin
			next_st.carrier = st.dcd_s;
			next_st.track = st.dcd_s;
		end else if (st.track) begin
			next_st.carrier = st.dcd_s;
			next_st.track = st.dcd_s;
		end
		next_st.irq = cause;
		next_st.rx_init = mr || st.dcd_s;
		next_st.tx_init = mr;
		if (mr) begin
			next_st.rx_full = 1'b0;
			next_st.framing = 1'b0;
			next_st.parity = 1'b0;
			next_st.overrun = 1'b0;
			next_st.ovr_pend = 1'b0;
			next_st.stat_seen = 1'b0;
			next_st.carrier = st.dcd_s;
			next_st.track = st.dcd_s;
			next_st.irq = 1'b0;
		end
	end

	// State register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st <= '0;
			st.control <= `CTRL_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	assign o_data_out = st.dout;
	assign o_data_oe = st.doe;
	assign o_irq_out = 1'b0;
	assign o_irq_oe = st.irq;
	assign o_tx_valid = fifo_valid;
	assign o_divide_sel = st.control[`CR_DIV1:`CR_DIV0];
	assign o_word_sel = st.control[`CR_WS2:`CR_WS0];
	assign o_tx_control = st.control[`CR_TX1:`CR_TX0];
	assign o_tx_parity_en = par_en;
	assign o_parity_odd = odd_sel;
	assign o_rx_init = st.rx_init;
	assign o_tx_init = st.tx_init;

	// Checks on the flag logic
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_data_read;
		acc == ACC_RDATA && !mr;
	endsequence

	// Enable high on a selected status read
	sequence s_status_read;
		st.e_s && st.cs_s && st.rw_s && !st.rs_s;
	endsequence

	// Status read drives status byte
	AST_STATUS_READ: assert property (
		s_status_read |=> o_data_oe && o_data_out == $past(status_byte))
		else $error("status byte not returned");

	// Load into empty holding
	AST_RXF_SET: assert property (
		(i_rx_load && !full_after && !mr) |=> st.rx_full && st.holding == $past(i_rx_char))
		else $error("receive full not set");

	// Carrier high masks full
	AST_RXF_MASK: assert property (
		st.dcd_s |-> !status_byte[`ST_RXF])
		else $error("receive full shown with carrier high");

	// Write clears empty
	AST_TRANSMIT_EMPTY_FLAG_CLR: assert property (
		(acc == ACC_TDATA && !mr) |=> !status_byte[`ST_TRANSMIT_EMPTY_FLAG])
		else $error("transmit empty not cleared");

	// Clear-to-send mirror and block
	AST_CTS: assert property (
		st.cts_s |-> status_byte[`ST_CTS] && !status_byte[`ST_TRANSMIT_EMPTY_FLAG])
		else $error("clear-to-send not honoured");

	// Rise sets loss flag
	AST_CARRIER_SET: assert property (
		(dcd_rise && !mr) |=> st.carrier)
		else $error("carrier loss not set");

	// Clearing sequence with input low
	AST_CARRIER_CLR: assert property (
		(st.stat_seen && !st.dcd_s && !st.dcd_m) ##0 s_data_read |=> !st.carrier)
		else $error("carrier loss not cleared");

	// Overrun revealed with full
	AST_OVR_SHOW: assert property (
		(st.ovr_pend && !i_rx_load) ##0 s_data_read |=> st.overrun && st.rx_full && !st.ovr_pend)
		else $error("overrun not revealed");

	// No parity keeps flag low
	AST_PE_OFF: assert property (
		!par_en |-> !status_byte[`ST_PE] && !o_tx_parity_en)
		else $error("parity flag active without parity");

	// Master reset clears status
	AST_MR: assert property (
		mr |=> !st.rx_full && !st.overrun && !st.framing && !st.irq)
		else $error("master reset left status");

	// Pin follows cause
	AST_IRQ: assert property (
		(cause && !mr) |=> o_irq_oe && status_byte[`ST_IRQ])
		else $error("interrupt not raised");

endmodule

/* serial_adapter_map.svh */
// Purpose: Field positions, codes, reset values and buffer shape of the adapter
// Assumes: Included by the status logic and its package users
// Notes: Definitions only
`ifndef SERIAL_ADAPTER_MAP_SVH
`define SERIAL_ADAPTER_MAP_SVH

// Status byte bit positions
`define ST_RXF 0
`define ST_TRANSMIT_EMPTY_FLAG 1
`define ST_CARRIER 2
`define ST_CTS 3
`define ST_FE 4
`define ST_OVR 5
`define ST_PE 6
`define ST_IRQ 7

// Control byte bit positions
`define CR_DIV0 0
`define CR_DIV1 1
`define CR_WS0 2
`define CR_WS1 3
`define CR_WS2 4
`define CR_TX0 5
`define CR_TX1 6
`define CR_RIE 7

// Control codes
`define CR_MR_CODE 2'h3
`define CR_TXIRQ_CODE 2'h1
`define CTRL_RESET 8'h03

// Transmit buffer shape
`define TX_FIFO_WIDTH 8
`define TX_FIFO_DEPTH 8

`endif

/* serial_adapter_pkg.sv */
// Purpose: Types shared by the adapter status logic
// Assumes: Positions and codes live in serial_adapter_map.svh
// Notes: One packed struct holds all state of the main module
package serial_adapter_pkg;

	// Kind of bus access decoded at the falling enable edge
	typedef enum logic [2:0] {
		ACC_NONE = 3'b000,
		ACC_STATUS = 3'b001,
		ACC_RDATA = 3'b010,
		ACC_CTRL = 3'b011,
		ACC_TDATA = 3'b100
	} access_e;

	// Complete state of the status logic
	typedef struct packed {
		logic e_m, e_s, e_p;
		logic cs_m, cs_s;
		logic rs_m, rs_s;
		logic rw_m, rw_s;
		logic [7:0] d_m, d_s;
		logic cts_m, cts_s;
		logic dcd_m, dcd_s, dcd_p;
		logic [7:0] control;
		logic [7:0] holding;
		logic rx_full, framing, parity, overrun, ovr_pend;
		logic carrier, track, stat_seen, irq;
		logic [7:0] dout;
		logic doe, rx_init, tx_init;
	} adapter_s;

endpackage

/* status_fifo.sv */
// Purpose: Small flip-flop FIFO with valid and ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes: Pushes while full and pops while empty are ignored
module status_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Filling side
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	// Draining side
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = AW + 1;
	localparam logic [AW:0] FULL_CNT = CW'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	// Storage, pointers and fill count
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} fifo_s;

	fifo_s st;
	fifo_s next_st;
	logic push; // Accepted write
	logic pop; // Accepted read

	// Next state of storage and pointers
	always_comb begin
		next_st = st;
		push = i_valid && (st.cnt != FULL_CNT);
		pop = i_ready && (st.cnt != '0);
		if (push) begin
			next_st.mem[st.wr] = i_data;
			next_st.wr = (st.wr == LAST) ? '0 : st.wr + 1'b1;
		end
		if (pop) begin
			next_st.rd = (st.rd == LAST) ? '0 : st.rd + 1'b1;
		end
		next_st.cnt = st.cnt + CW'(push) - CW'(pop);
	end

	// State register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Honest full and empty
	assign o_ready = (st.cnt != FULL_CNT);
	assign o_valid = (st.cnt != '0);
	assign o_data = st.mem[st.rd];

endmodule

/* serial_far_end.sv */
// Purpose: Serializer stand-in that takes characters from the transmit FIFO
// Assumes: Strobes change on the falling clock edge
// Notes: i_stall holds characters back; i_slow spaces the takes apart
module serial_far_end (
	// Clock
	input wire logic i_clk,
	// Transmit side of the adapter
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_char,
	output logic o_tx_take,
	// Pacing from the bench
	input wire logic i_stall,
	input wire logic i_slow
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got[$]; // Characters taken so far
	int gap = 0; // Cycles left before the next take
	initial o_tx_take = 1'b0;
	always @(negedge i_clk) begin
		o_tx_take <= 1'b0;
		if (gap > 0) begin
			gap <= gap - 1;
		end else if (i_tx_valid && !i_stall && !o_tx_take) begin
			o_tx_take <= 1'b1;
			got.push_back(i_tx_char);
			gap <= i_slow ? 5 : 1;
		end
	end
endmodule

/* tb_serial_adapter_status_logic.sv */
// Purpose: Self-checking bench of the adapter status logic
// Assumes: Bus pins driven on the falling clock edge
// Notes: Expected status bytes come from st() and pe_exp()
module tb_serial_adapter_status_logic;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, en = 0, cs = 0, rsel = 0, rw = 1, cts = 0, dcd = 0;
	logic rxl = 0, rxp = 0, rxs = 0, take, stall = 0, slow = 0, tv, irq_oe;
	logic [7:0] din = 8'h00, dout, rxc = 8'h00, tc, ctl = 8'h03; // Ctl mirrors control
	logic oe, irq_o, rxi, txi, tpe, podd; // Bus enable, pin level, inits, parity outputs
	logic [1:0] dsel, tctl; // Divide and transmitter control fields
	logic [2:0] wsel; // Word format field
	int n_fail = 0, num_checks = 0;
	// Clock of 10 ns
	initial forever #5 clk = ~clk;
	serial_adapter_status_logic i_dut (
		.i_clk(clk), .i_rst(rst), .i_enable(en), .i_chip_sel(cs),
		.i_register_select(rsel), .i_read_write(rw), .i_data_in(din),
		.o_data_out(dout), .o_data_oe(oe), .i_clear_to_send(cts),
		.i_carrier_loss_input(dcd), .o_irq_out(irq_o), .o_irq_oe(irq_oe),
		.o_tx_valid(tv), .o_tx_char(tc), .i_tx_take(take), .i_rx_load(rxl),
		.i_rx_char(rxc), .i_rx_parity_bit(rxp), .i_rx_stop_missing(rxs),
		.o_divide_sel(dsel), .o_word_sel(wsel), .o_tx_control(tctl), .o_tx_parity_en(tpe),
		.o_parity_odd(podd), .o_rx_init(rxi), .o_tx_init(txi)
	);
	serial_far_end i_far (
		.i_clk(clk), .i_tx_valid(tv), .i_tx_char(tc), .o_tx_take(take),
		.i_stall(stall), .i_slow(slow)
	);
	// Verdict and end of run
	task end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Byte comparison
	task chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// One bus access; data sampled while enable is high, action at its fall
	task bus(input logic r, input logic rdn, input logic [7:0] d, output logic [7:0] q);
		cs = 1;
		rsel = r;
		rw = rdn;
		din = d;
		en = 1;
		cyc(6);
		q = dout;
		chk({6'h00, irq_o, oe}, {6'h00, 1'b0, rdn});
		if (rdn && !r) chk({7'h00, irq_oe}, {7'h00, q[7]});
		en = 0;
		cyc(6);
		cs = 0;
		cyc(1);
	endtask
	task rd(input logic r, input logic [7:0] exp);
		logic [7:0] q;
		bus(r, 1'b1, 8'h00, q);
		chk(q, exp);
	endtask
	task wr(input logic r, input logic [7:0] d);
		logic [7:0] q;
		bus(r, 1'b0, d, q);
	endtask
	task setc(input logic [7:0] d);
		ctl = d;
		wr(1'b0, d);
		chk({1'b0, tctl, wsel, dsel}, {1'b0, d[6:0]});
		chk({6'h00, tpe, podd}, {6'h00, (d[4:3] != 2'b10), d[2]});
	endtask
	// One-cycle receive transfer
	task load(input logic [7:0] c, input logic p, input logic s);
		rxc = c;
		rxp = p;
		rxs = s;
		rxl = 1;
		cyc(1);
		rxl = 0;
		cyc(2);
	endtask
	// Expected status byte from the flags and the control byte
	function automatic logic [7:0] st(input logic rf, td, cr, fe, ov, pe);
		logic iq;
		iq = (ctl[7] & (rf | cr)) | ((ctl[6:5] == 2'b01) & td);
		return {iq, pe, ov, fe, cts, cr, td, rf};
	endfunction
	// Expected parity flag for the current word format
	function automatic logic pe_exp(input logic [7:0] c, input logic p);
		if (ctl[4:3] == 2'b10) return 1'b0;
		return ((ctl[4] ? ^c : ^c[6:0]) ^ p) != ctl[2];
	endfunction
	initial begin
		logic [7:0] c, r, q;
		void'($urandom(32'h5987));
		cyc(16);
		rst = 0;
		cyc(2);
		setc(8'h95);
		rd(0, st(0, 1, 0, 0, 0, 0));
		// Every word format with random characters and errors
		for (int i = 0; i < 24; i++) begin
			r = $urandom;
			setc({r[7:5], i[2:0], 2'b01});
			c = $urandom;
			c[7] = c[7] & ctl[4];
			r = $urandom;
			load(c, r[0], r[1]);
			rd(0, st(1, 1, 0, r[1], 0, pe_exp(c, r[0])));
			rd(1, c);
			rd(0, st(0, 1, 0, r[1], 0, pe_exp(c, r[0])));
		end
		// Two characters without a read in between
		setc(8'h95);
		load(8'h5a, 0, 0);
		load(8'ha5, 0, 0);
		rd(0, st(1, 1, 0, 0, 0, 0));
		rd(1, 8'h5a);
		rd(0, st(1, 1, 0, 0, 1, 0));
		bus(1, 1, 8'h00, q);
		rd(0, st(0, 1, 0, 0, 0, 0));
		// Carrier loss with a character held
		load(8'h3c, 0, 0);
		dcd = 1;
		cyc(6);
		chk({6'h00, rxi, txi}, 8'h02);
		rd(0, st(0, 1, 1, 0, 0, 0));
		bus(1, 1, 8'h00, q);
		rd(0, st(0, 1, 1, 0, 0, 0));
		dcd = 0;
		cyc(6);
		rd(0, st(0, 1, 0, 0, 0, 0));
		rd(1, 8'h3c);
		dcd = 1;
		cyc(6);
		dcd = 0;
		cyc(6);
		bus(1, 1, 8'h00, q);
		rd(0, st(0, 1, 1, 0, 0, 0));
		bus(1, 1, 8'h00, q);
		rd(0, st(0, 1, 0, 0, 0, 0));
		// Fill the transmit FIFO past full with the far end stalled
		setc(8'h35);
		stall = 1;
		slow = 1;
		for (int i = 0; i < 9; i++) wr(1, 8'h10 + i[7:0]);
		rd(0, st(0, 0, 0, 0, 0, 0));
		cts = 1;
		stall = 0;
		for (int k = 0; k < 400 && i_far.got.size() < 8; k++) cyc(1);
		if (i_far.got.size() != 8) begin
			n_fail++;
			end_sim();
		end
		for (int i = 0; i < 8; i++) chk(i_far.got[i], 8'h10 + i[7:0]);
		rd(0, st(0, 0, 0, 0, 0, 0));
		chk({6'h00, rxi, txi}, 8'h00);
		cts = 0;
		cyc(6);
		rd(0, st(0, 1, 0, 0, 0, 0));
		// Master reset clears flags but not the modem bit
		setc(8'h95);
		load(8'h11, 0, 1);
		load(8'h22, 0, 0);
		cts = 1;
		setc(8'h03);
		rd(0, st(0, 0, 0, 0, 0, 0));
		chk({6'h00, rxi, txi}, 8'h03);
		cts = 0;
		setc(8'h95);
		rd(0, st(0, 1, 0, 0, 0, 0));
		end_sim();
	end
endmodule
